// file: src/sec_eeprom.sv
/*
  sec_eeprom: serial command front end, status register and write protection.
  assumes: the serial pins come from another clock domain and are synchronised
  here; the serial clock is far slower than MCLK.
*/
`timescale 1ns/1ps
// Overview of operation
// - input bits are captured on each rising serial clock edge.
// - output bits change on each falling serial clock edge.
// - deselected means output floats; standby unless a write cycle runs.
// - nothing is accepted in the first chip select frame after reset.
// - pause low floats output and freezes all serial activity.
// - both clock modes zero-zero and one-one work.
// - 06 sets the write latch, 04 clears it.
// - 05 reads status, 01 writes status.
// - 03 reads memory, 02 writes memory.
// - eight-bit instruction loaded; unknown opcodes are ignored.
// - status layout lock, id select, fast, id lock, guard hi, lo, latch, busy.
// - busy is one during a write cycle and host cannot write it.
// - guard field protects none, top quarter, top half or all.
// - fast write select picks standard or fast write timing.
// - latch clear refuses all writes; guarded blocks never writable.
// - hardware protection needs protect pin low and lock bit one.
// - id select routes accesses to the identification page.
// - id select clears itself after an access using it.
// - id lock makes the identification page read-only.
// - setting id select and id lock together changes neither.
// - an extra 256-byte identification page exists.
// - main array is 262144 bytes of eight bits.
// - during a write cycle only status reads are obeyed.
// - a 24-bit address follows; only the low 18 bits matter.
// - status writes load only bits 2 to 7; the write cycle also clears the latch bit.
// - page load wraps the low byte address within the page.
module sec_eeprom
  import sec_pkg::*;
#(
  parameter int STD_CYC  = WRITE_STD_CYC,
  parameter int FAST_CYC = WRITE_FAST_CYC
) (
  input  wire logic MCLK,     // system clock, 125 MHz
  input  wire logic RST,      // synchronous reset, active high
  input  wire logic SCK,      // serial clock pin
  input  wire logic CS_N,     // chip select, active low
  input  wire logic SI,       // serial data in
  input  wire logic HOLD_N,   // pause, active low
  input  wire logic WP_N,     // write protect, active low
  output logic      SO,       // serial data out
  output logic      SO_OE_N   // output enable, low while driving
);

  typedef struct packed {
    logic [1:0]  sck_s;
    logic [1:0]  cs_s;
    logic [1:0]  si_s;
    logic [1:0]  hold_s;
    logic [1:0]  wp_s;
    logic        sck_d;
    logic        cs_d;
    logic        armed;
    sec_phase_e  phase;
    logic [2:0]  bitc;
    logic [1:0]  bytec;
    logic [7:0]  shin;
    logic [7:0]  shout;
    logic [7:0]  op;
    logic [17:0] addr;
    logic        did_id;
    logic        wr_pend;
    logic [7:0]  stat_new;
    logic        stat_pend;
    logic        stat_busy;
    logic [31:0] wcnt;
    logic        rd_req;
    logic        so;
    logic        so_oe_n;
    logic        out_on;
    sec_word_s   word;
    logic        word_v;
    logic        lock_en;
    logic        id_sel;
    logic        fast;
    logic        id_lock;
    logic [1:0]  guard;
    logic        latch;
  } sec_st_s;

  sec_st_s    st_r;
  sec_st_s    st_nxt;
  logic       wr_ready;
  logic [7:0] rd_data;
  logic       pending;
  logic       busy;
  logic       drain_en;

  function automatic logic guarded(input logic [1:0] g, input logic [17:0] a);
    case (g)
      2'b01:   guarded = (a >= QUARTER_BASE);
      2'b10:   guarded = (a >= HALF_BASE);
      2'b11:   guarded = 1'b1;
      default: guarded = 1'b0;
    endcase
  endfunction

  function automatic logic [7:0] stat_byte(input sec_st_s s, input logic b);
    stat_byte = {s.lock_en, s.id_sel, s.fast, s.id_lock, s.guard, s.latch, b};
  endfunction

  assign busy = st_r.wcnt != 32'd0 || pending;
  assign drain_en = st_r.wcnt == 32'd1;

  sec_mem u_mem (
    .clk      (MCLK),
    .rst      (RST),
    .wr_word  (st_r.word),
    .wr_valid (st_r.word_v),
    .wr_ready (wr_ready),
    .drain_en (drain_en),
    .rd_addr  (st_r.addr),
    .rd_id    (st_r.id_sel),
    .rd_data  (rd_data),
    .pending  (pending)
  );

  always_comb begin
    logic rise;
    logic fall;
    logic act;
    logic hw_prot;
    logic [7:0] byte_in;
    logic [7:0] wv;
    logic [7:0] sb;
    rise = 1'b0;
    fall = 1'b0;
    act = 1'b0;
    hw_prot = 1'b0;
    byte_in = 8'h00;
    wv = 8'h00;
    sb = 8'h00;
    st_nxt = st_r;
    st_nxt.sck_s  = {st_r.sck_s[0], SCK};
    st_nxt.cs_s   = {st_r.cs_s[0], CS_N};
    st_nxt.si_s   = {st_r.si_s[0], SI};
    st_nxt.hold_s = {st_r.hold_s[0], HOLD_N};
    st_nxt.wp_s   = {st_r.wp_s[0], WP_N};
    st_nxt.sck_d  = st_r.sck_s[1];
    st_nxt.cs_d   = st_r.cs_s[1];
    // freeze edge detection while paused
    act  = !st_r.cs_s[1] && st_r.hold_s[1];
    rise = act && st_r.sck_s[1] && !st_r.sck_d;
    fall = act && !st_r.sck_s[1] && st_r.sck_d;
    hw_prot = !st_r.wp_s[1] && st_r.lock_en;
    st_nxt.rd_req = 1'b0;
    if (st_r.word_v && wr_ready) begin
      st_nxt.word_v = 1'b0;
    end
    if (st_r.wcnt > 32'd1) begin
      st_nxt.wcnt = st_r.wcnt - 32'd1;
    end else if (st_r.wcnt == 32'd1 && !pending) begin
      st_nxt.wcnt = 32'd0;
      if (st_r.stat_busy) begin
        st_nxt.lock_en = st_r.stat_new[SB_LOCK_EN];
        st_nxt.id_lock = st_r.stat_new[SB_ID_LOCK];
        st_nxt.guard   = st_r.stat_new[SB_GUARD_HI:SB_GUARD_LO];
        st_nxt.stat_busy = 1'b0;
      end
    end
    if (st_r.cs_d && !st_r.cs_s[1]) begin
      st_nxt.armed = 1'b1;
      st_nxt.phase = st_r.armed ? PH_OPCODE : PH_SKIP;
      st_nxt.bitc  = 3'd0;
      st_nxt.bytec = 2'd0;
      st_nxt.did_id = 1'b0;
      st_nxt.out_on = 1'b0;
    end
    if (!st_r.cs_d && st_r.cs_s[1]) begin
      // rising chip select ends the frame and starts programming
      if (st_r.did_id) begin
        st_nxt.id_sel = 1'b0;
      end
      if (st_r.wr_pend && st_r.bitc == 3'd0) begin
        st_nxt.wcnt  = st_r.fast ? 32'(FAST_CYC) : 32'(STD_CYC);
        st_nxt.latch = 1'b0;
      end
      if (st_r.stat_pend && st_r.bitc == 3'd0 && !hw_prot) begin
        wv = st_r.stat_new;
        if (wv[SB_ID_SEL] && wv[SB_ID_LOCK]) begin
          wv[SB_ID_SEL] = st_r.id_sel;
          wv[SB_ID_LOCK] = st_r.id_lock;
        end
        if (st_r.id_lock) begin
          wv[SB_ID_LOCK] = 1'b1;
        end
        st_nxt.id_sel  = wv[SB_ID_SEL];
        st_nxt.fast    = wv[SB_FAST];
        st_nxt.stat_new = wv;
        st_nxt.stat_busy = 1'b1;
        st_nxt.wcnt  = st_r.fast ? 32'(FAST_CYC) : 32'(STD_CYC);
        st_nxt.latch = 1'b0;
      end
      st_nxt.wr_pend = 1'b0;
      st_nxt.stat_pend = 1'b0;
      st_nxt.out_on = 1'b0;
      st_nxt.phase = PH_IDLE;
    end
    if (st_r.cs_s[1]) begin
      st_nxt.so_oe_n = 1'b1;
    end else if (!st_r.hold_s[1]) begin
      st_nxt.so_oe_n = 1'b1;
    end else if (st_r.out_on) begin
      // drive again once a pause ends inside an output byte
      st_nxt.so_oe_n = 1'b0;
    end
    if (rise && st_r.phase != PH_IDLE && st_r.phase != PH_SKIP) begin
      byte_in = {st_r.shin[6:0], st_r.si_s[1]};
      st_nxt.shin = byte_in;
      st_nxt.bitc = st_r.bitc + 3'd1;
      if (st_r.bitc == 3'd7) begin
        case (st_r.phase)
          PH_OPCODE: begin
            st_nxt.op = byte_in;
            st_nxt.phase = PH_SKIP;
            if (byte_in == OP_STAT_READ) begin
              st_nxt.phase = PH_STAT_OUT;
            end else if (!busy) begin
              case (byte_in)
                OP_SET_LATCH: st_nxt.latch = 1'b1;
                OP_CLR_LATCH: st_nxt.latch = 1'b0;
                OP_STAT_WRITE: begin
                  if (st_r.latch) begin
                    st_nxt.phase = PH_STAT_IN;
                  end
                end
                OP_MEM_READ, OP_MEM_WRITE: begin
                  st_nxt.phase = PH_ADDR;
                  st_nxt.bytec = 2'd0;
                end
                default: st_nxt.phase = PH_SKIP;
              endcase
            end
          end
          PH_ADDR: begin
            // only the low 18 of 24 address bits are kept
            st_nxt.addr = {st_r.addr[9:0], byte_in};
            st_nxt.bytec = st_r.bytec + 2'd1;
            if (st_r.bytec == 2'(ADDR_BYTES - 1)) begin
              st_nxt.did_id = st_r.id_sel;
              if (st_r.op == OP_MEM_READ) begin
                st_nxt.phase = PH_DATA_OUT;
                st_nxt.rd_req = 1'b1;
              end else begin
                st_nxt.phase = PH_DATA_IN;
              end
            end
          end
          PH_DATA_IN: begin
            // refuse guarded, locked or unlatched targets
            if (st_r.latch && !(st_r.id_sel ? (st_r.id_lock || st_r.guard == 2'b11)
                                           : guarded(st_r.guard, st_r.addr))) begin
              st_nxt.word.data    = byte_in;
              st_nxt.word.addr    = st_r.addr;
              st_nxt.word.id_page = st_r.id_sel;
              st_nxt.word_v  = 1'b1;
              st_nxt.wr_pend = 1'b1;
            end
            st_nxt.addr[PAGE_BITS-1:0] = st_r.addr[PAGE_BITS-1:0] + 8'h01;
          end
          PH_STAT_IN: begin
            st_nxt.stat_new  = (byte_in & STAT_WR_MASK) | (stat_byte(st_r, 1'b0) & ~STAT_WR_MASK);
            st_nxt.stat_pend = 1'b1;
          end
          default: st_nxt.phase = st_r.phase;
        endcase
      end
    end
    if (fall) begin
      case (st_r.phase)
        PH_STAT_OUT: begin
          if (st_r.bitc == 3'd0) begin
            sb = stat_byte(st_r, busy);
            st_nxt.shout = {sb[6:0], 1'b0};
            st_nxt.so = sb[7];
          end else begin
            st_nxt.so = st_r.shout[7];
            st_nxt.shout = {st_r.shout[6:0], 1'b0};
          end
          st_nxt.so_oe_n = 1'b0;
          st_nxt.out_on = 1'b1;
        end
        PH_DATA_OUT: begin
          if (st_r.bitc == 3'd0) begin
            st_nxt.shout = {rd_data[6:0], 1'b0};
            st_nxt.so = rd_data[7];
            st_nxt.addr = st_r.id_sel ? {st_r.addr[17:8], st_r.addr[7:0] + 8'h01}
                                      : st_r.addr + 18'h00001;
          end else begin
            st_nxt.so = st_r.shout[7];
            st_nxt.shout = {st_r.shout[6:0], 1'b0};
          end
          st_nxt.so_oe_n = 1'b0;
          st_nxt.out_on = 1'b1;
        end
        default: st_nxt.so_oe_n = 1'b1;
      endcase
    end
    if ((st_r.phase == PH_DATA_OUT || st_r.phase == PH_STAT_OUT) && rise) begin
      st_nxt.bitc = st_r.bitc + 3'd1;
    end
    if (RST) begin
      st_nxt = '0;
      st_nxt.phase = PH_IDLE;
      st_nxt.cs_s = 2'b11;
      st_nxt.cs_d = 1'b1;
      st_nxt.hold_s = 2'b11;
      st_nxt.wp_s = 2'b11;
      st_nxt.so_oe_n = 1'b1;
    end
  end

  always_ff @(posedge MCLK) begin
    st_r <= st_nxt;
  end

  assign SO      = st_r.so;
  assign SO_OE_N = st_r.so_oe_n;

endmodule

// file: src/sec_pkg.sv
/*
  sec_pkg: constants and carrier types for the serial EEPROM command front end.
  assumes: imported whole by every design file of the block.
*/
package sec_pkg;

  localparam logic [7:0] OP_SET_LATCH   = 8'h06;
  localparam logic [7:0] OP_CLR_LATCH   = 8'h04;
  localparam logic [7:0] OP_STAT_READ   = 8'h05;
  localparam logic [7:0] OP_STAT_WRITE  = 8'h01;
  localparam logic [7:0] OP_MEM_READ    = 8'h03;
  localparam logic [7:0] OP_MEM_WRITE   = 8'h02;

  // status bit positions
  localparam int SB_BUSY     = 0;
  localparam int SB_LATCH    = 1;
  localparam int SB_GUARD_LO = 2;
  localparam int SB_GUARD_HI = 3;
  localparam int SB_ID_LOCK  = 4;
  localparam int SB_FAST     = 5;
  localparam int SB_ID_SEL   = 6;
  localparam int SB_LOCK_EN  = 7;

  localparam logic [7:0] STAT_WR_MASK  = 8'hfc;
  localparam logic [7:0] STAT_RESET    = 8'h00;

  localparam int ADDR_BITS  = 18;
  localparam int PAGE_BITS  = 8;
  localparam int ADDR_BYTES = 3;
  localparam logic [17:0] QUARTER_BASE = 18'h30000;
  localparam logic [17:0] HALF_BASE    = 18'h20000;

  localparam real CLK_NS       = 8.0;
  localparam real WRITE_STD_MS = 6.0;
  localparam real WRITE_FAST_MS = 3.0;
  localparam int  WRITE_STD_CYC  = int'(WRITE_STD_MS * 1.0e6 / CLK_NS);
  localparam int  WRITE_FAST_CYC = int'(WRITE_FAST_MS * 1.0e6 / CLK_NS);

  typedef enum logic [2:0] {
    PH_IDLE, PH_OPCODE, PH_ADDR, PH_DATA_IN, PH_DATA_OUT, PH_STAT_IN, PH_STAT_OUT, PH_SKIP
  } sec_phase_e;

  typedef struct packed {
    logic [7:0]  data;
    logic [17:0] addr;
    logic        id_page;
  } sec_word_s;

endpackage

// file: src/sec_mem.sv
/*
  sec_mem: byte memory with registered read data and a two-entry write buffer.
  assumes: single clock; writes are accepted through a valid/ready pair.
*/
`timescale 1ns/1ps
module sec_mem
  import sec_pkg::*;
#(
  parameter int DEPTH = 262144,
  parameter int IDEPTH = 256
) (
  input  wire logic              clk,       // system clock
  input  wire logic              rst,       // synchronous reset
  input  wire sec_word_s         wr_word,   // write word
  input  wire logic              wr_valid,  // write request
  output logic                   wr_ready,  // buffer has room
  input  wire logic              drain_en,  // allow the buffer to drain
  input  wire logic [17:0]       rd_addr,   // read address
  input  wire logic              rd_id,     // read from id page
  output logic [7:0]             rd_data,   // registered read data
  output logic                   pending    // buffer not empty
);

  typedef struct packed {
    sec_word_s [1:0] slot;
    logic [1:0]      cnt;
    logic [7:0]      rd;
  } sec_mem_s;

  logic [7:0] main_mem [DEPTH];
  logic [7:0] id_mem   [IDEPTH];
  sec_mem_s   st_r;
  sec_mem_s   st_nxt;
  logic       pop;
  logic       push;

  always_comb begin
    st_nxt = st_r;
    push = wr_valid && (st_r.cnt != 2'd2);
    pop  = drain_en && (st_r.cnt != 2'd0);
    if (pop) begin
      st_nxt.slot[0] = st_r.slot[1];
    end
    if (push) begin
      if (pop) begin
        st_nxt.slot[st_r.cnt - 2'd1] = wr_word;
      end else begin
        st_nxt.slot[st_r.cnt[0]] = wr_word;
      end
    end
    st_nxt.cnt = st_r.cnt + {1'b0, push} - {1'b0, pop};
    st_nxt.rd = rd_id ? id_mem[rd_addr[PAGE_BITS-1:0]] : main_mem[rd_addr];
    if (rst) begin
      st_nxt.cnt = 2'd0;
      st_nxt.rd  = 8'h00;
    end
  end

  always_ff @(posedge clk) begin
    st_r <= st_nxt;
    if (pop && !rst) begin
      if (st_r.slot[0].id_page) begin
        id_mem[st_r.slot[0].addr[PAGE_BITS-1:0]] <= st_r.slot[0].data;
      end else begin
        main_mem[st_r.slot[0].addr] <= st_r.slot[0].data;
      end
    end
  end

  assign wr_ready = (st_r.cnt != 2'd2);
  assign rd_data  = st_r.rd;
  assign pending  = (st_r.cnt != 2'd0);

endmodule

// file: testbench/sec_eeprom_properties.sv
/* sec_eeprom_properties: port checker for the serial front end.
   assumes: bound to sec_eeprom; SCK far slower than MCLK. */
`timescale 1ns/1ps
module sec_eeprom_properties
  import sec_pkg::*;
#(
  parameter int STD_CYC  = 50,
  parameter int FAST_CYC = 50
) (
  input wire logic MCLK,    // clock
  input wire logic RST,     // sync reset
  input wire logic SCK,     // serial clock
  input wire logic CS_N,    // chip select
  input wire logic SI,      // serial in
  input wire logic HOLD_N,  // pause
  input wire logic WP_N,    // protect pin
  input wire logic SO,      // serial out
  input wire logic SO_OE_N  // out enable
);
  logic       sck_q;
  logic       cs_q;
  logic [3:0] age;
  logic [3:0] rises;
  logic [1:0] falls;
  logic [7:0] op;
  // age: cycles since a seen SCK fall; rises: SCK rises in frame
  always_ff @(posedge MCLK) begin
    sck_q <= SCK;
    cs_q <= CS_N;
    if (RST) begin
      age <= 4'hf;
      rises <= 4'h0;
      falls <= 2'h0;
    end else begin
      age <= (sck_q && !SCK) ? 4'h0 : ((age == 4'hf) ? age : age + 4'h1);
      if (CS_N) begin
        rises <= 4'h0;
      end else if (!sck_q && SCK && HOLD_N && rises != 4'hf) begin
        rises <= rises + 4'h1;
        if (rises < 4'h8) op <= {op[6:0], SI};
      end
      if (cs_q && !CS_N && falls != 2'h3) falls <= falls + 2'h1;
    end
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  sequence s_deselected;
    CS_N [*6];
  endsequence
  sequence s_opcode_in;
    !CS_N && rises >= 4'h8;
  endsequence
  a_desel_float: assert property (s_deselected |-> SO_OE_N)
    else $error("output driven while deselected");
  a_cs_release: assert property ($rose(CS_N) |-> ##[1:6] SO_OE_N)
    else $error("output not released after deselect");
  a_hold_float: assert property ((!HOLD_N) [*6] |-> SO_OE_N)
    else $error("output driven during pause");
  a_so_on_fall: assert property (!SO_OE_N && $past(!SO_OE_N) && $changed(SO) |-> age <= 4'h6)
    else $error("output changed away from a falling serial clock");
  a_oe_after_op: assert property ($fell(SO_OE_N) |-> s_opcode_in)
    else $error("output driven before a whole opcode");
  a_bad_op_quiet: assert property (s_opcode_in ##0 (op != OP_STAT_READ && op != OP_MEM_READ)
    |-> SO_OE_N)
    else $error("output driven for a non-read opcode");
  a_arm_quiet: assert property (falls == 2'h1 |-> SO_OE_N)
    else $error("output driven in the arming frame");
  a_oe_selected: assert property ($fell(SO_OE_N) |-> $past(!CS_N, 2) && $past(HOLD_N, 2))
    else $error("output enabled while not selected or paused");
endmodule
bind sec_eeprom sec_eeprom_properties #(.STD_CYC(STD_CYC), .FAST_CYC(FAST_CYC))
  sec_eeprom_properties_i (.MCLK(MCLK), .RST(RST), .SCK(SCK), .CS_N(CS_N), .SI(SI),
  .HOLD_N(HOLD_N), .WP_N(WP_N), .SO(SO), .SO_OE_N(SO_OE_N));

// file: testbench/sec_spi_host.sv
/* sec_spi_host: host serial controller model driving frames.
   assumes: clk is the bench clock; pins change on its falling edge. */
`timescale 1ns/1ps
module sec_spi_host (
  input  wire logic clk,      // bench clock
  input  wire logic so_wire,  // resolved serial out line
  output logic      sck,      // serial clock
  output logic      cs_n,     // chip select
  output logic      si,       // serial data to device
  output logic      hold_n    // pause
);
  logic cpol;
  initial begin
    cpol = 1'b0;
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    hold_n = 1'b1;
  end
  task automatic half(input int n);
    repeat (8 * n) @(negedge clk);
  endtask
  // msb first, data set at the fall, both sides take it at the rise
  task automatic xfer(input logic [7:0] tx, input int hold_at, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sck = 1'b0;
      si = tx[i];
      half(1);
      if (i == hold_at) begin
        hold_n = 1'b0;
        repeat (3) begin
          sck = 1'b1;
          si = ~si;
          half(1);
          sck = 1'b0;
          half(1);
        end
        hold_n = 1'b1;
        half(1);
      end
      rx[i] = so_wire;
      sck = 1'b1;
      half(1);
    end
  endtask
  // one frame: opcode then address/data bytes, clock idles at cpol
  task automatic frame(input logic [47:0] tx, input int n, input int hold_at,
                       output logic [47:0] rx);
    logic [7:0] r;
    rx = '0;
    sck = cpol;
    cs_n = 1'b0;
    half(1);
    for (int k = 0; k < n; k++) begin
      xfer(tx[8*(n-1-k) +: 8], (k == n - 1) ? hold_at : -1, r);
      rx = {rx[39:0], r};
    end
    sck = cpol;
    half(1);
    cs_n = 1'b1;
    si = ~si;
    half(4);
  endtask
endmodule

// file: testbench/tb_top.sv
/* tb_top: self-checking bench for the serial EEPROM front end.
   assumes: sec_spi_host plays the host; short write-cycle counts. */
`timescale 1ns/1ps
module tb_top;
  import sec_pkg::*;
  logic        MCLK, RST, SCK, CS_N, SI, HOLD_N, WP_N, SO, SO_OE_N;
  logic        so_wire;
  logic [47:0] rx;
  int          errors, cmp_count;
  assign so_wire = SO_OE_N ? 1'bz : SO;
  sec_eeprom #(.STD_CYC(3000), .FAST_CYC(1500)) sec_eeprom_i (.MCLK(MCLK), .RST(RST),
    .SCK(SCK), .CS_N(CS_N), .SI(SI), .HOLD_N(HOLD_N), .WP_N(WP_N), .SO(SO), .SO_OE_N(SO_OE_N));
  sec_spi_host sec_spi_host_i (.clk(MCLK), .so_wire(so_wire), .sck(SCK), .cs_n(CS_N),
    .si(SI), .hold_n(HOLD_N));
  initial begin
    MCLK = 1'b0;
    forever #4 MCLK = ~MCLK;
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic run(input logic [47:0] tx, input int n);
    sec_spi_host_i.frame(tx, n, -1, rx);
  endtask
  task automatic st_is(input string what, input logic [7:0] exp);
    run(16'h0500, 2);
    check(what, rx[7:0], exp);
  endtask
  task automatic idle();
    for (int i = 0; i < 40; i++) begin
      run(16'h0500, 2);
      if (rx[0] === 1'b0) break;
    end
  endtask
  task automatic t_arm();
    run(16'h0500, 2);
    check("arming frame", rx[7:0], 8'hzz);
    st_is("status after reset", 8'h00);
    $display("done t_arm");
  endtask
  task automatic t_latch();
    for (int m = 0; m < 2; m++) begin
      sec_spi_host_i.cpol = m[0];
      run(8'h06, 1);
      st_is("latch set", 8'h02);
      run(8'h04, 1);
      st_is("latch clear", 8'h00);
    end
    sec_spi_host_i.cpol = 1'b0;
    $display("done t_latch");
  endtask
  task automatic t_badop();
    logic [7:0] ops [5] = '{8'h07, 8'h60, 8'h86, 8'h00, 8'hff};
    run(8'h06, 1);
    foreach (ops[i]) begin
      run({ops[i], 8'h00}, 2);
      check("unknown opcode", rx[7:0], 8'hzz);
    end
    st_is("latch kept", 8'h02);
    run(8'h04, 1);
    $display("done t_badop");
  endtask
  task automatic t_stwr();
    run(8'h06, 1);
    run(16'h01a7, 2);
    st_is("busy in write", 8'h21);
    run(8'h06, 1);
    idle();
    st_is("status written", 8'ha4);
    $display("done t_stwr");
  endtask
  task automatic t_prot();
    run(16'h0100, 2);
    st_is("no latch", 8'ha4);
    WP_N = 1'b0;
    run(8'h06, 1);
    run(16'h0100, 2);
    st_is("hw protect", 8'ha6);
    WP_N = 1'b1;
    run(16'h0100, 2);
    idle();
    st_is("unprotected", 8'h00);
    run(8'h06, 1);
    run(16'h0150, 2);
    idle();
    st_is("id bits both", 8'h00);
    $display("done t_prot");
  endtask
  task automatic t_mem();
    run(8'h06, 1);
    run(48'h02ffffffa1a2, 6);
    idle();
    run(40'h0303ffff00, 5);
    check("top byte", rx[7:0], 8'ha1);
    run(40'h0303ff0000, 5);
    check("page wrap", rx[7:0], 8'ha2);
    run(8'h06, 1);
    run(16'h0104, 2);
    idle();
    run(8'h06, 1);
    run(40'h0203ffff77, 5);
    st_is("guarded refuse", 8'h06);
    run(40'h0202ffff3c, 5);
    idle();
    run(40'h0303ffff00, 5);
    check("guarded kept", rx[7:0], 8'ha1);
    run(40'h0302ffff00, 5);
    check("open block", rx[7:0], 8'h3c);
    sec_spi_host_i.frame(16'h0500, 2, 4, rx);
    check("paused read", rx[7:0], 8'h04);
    $display("done t_mem");
  endtask
  task automatic set_stat(input logic [7:0] v);
    run(8'h06, 1);
    run({8'h01, v}, 2);
    idle();
  endtask
  task automatic t_idpg();
    set_stat(8'h40);
    st_is("id select", 8'h40);
    run(8'h06, 1);
    run(40'h020000105a, 5);
    idle();
    st_is("id select cleared", 8'h00);
    set_stat(8'h40);
    run(40'h0300001000, 5);
    check("id page byte", rx[7:0], 8'h5a);
    set_stat(8'h10);
    set_stat(8'h40);
    st_is("id lock kept", 8'h50);
    run(8'h06, 1);
    run(40'h020000106b, 5);
    st_is("locked page refuse", 8'h12);
    $display("done t_idpg");
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    errors = 0;
    cmp_count = 0;
    RST = 1'b1;
    WP_N = 1'b1;
    repeat (8) @(negedge MCLK);
    RST = 1'b0;
    t_arm();
    t_latch();
    t_badop();
    t_stwr();
    t_prot();
    t_mem();
    t_idpg();
    end_of_test();
  end
  initial begin
    repeat (95000) @(posedge MCLK);
    errors++;
    $display("FAIL watchdog expected finish seen timeout");
    end_of_test();
  end
endmodule
